// ===== logic_cluster_pkg.sv
// constants and carrier types for the logic cluster and its cells
// Notes on behaviour
// - at most ten control signals per cluster
// - three clocks, enables, two aclr, sclr, sload
// - three clocks from two sources, three enables
// - each cluster clock tied to own enable
// - rising and falling edges use separate clocks
// - dropping an enable stops its clock
// - controls come from six row lines, local
// - two lookup halves, two flops, eight inputs
// - any six-input, some seven-input functions
// - flops have data, clock, enable, clears, load
// - combinational use bypasses the flop
// - two driver sets, two routes, one local
// - lookup and flop drive separate outputs
// - flop output feeds back into lookup
// - registered and unregistered result together
// - eleven inputs steered by mode
// - cluster controls govern flops in all modes
// - two functions or one six-input function
// - five-five shares a,b; four-five shares one
// - two six-input need four common, same function; code shares a-d but keeps separate lut_top and lut_bot masks
// - six-input uses a-d plus top or bottom pair
// - bottom pair use frees top pair for packing
`default_nettype none
package logic_cluster_pkg;
   // ----------------------------------------
   // sizes and reset values
   // ----------------------------------------
   localparam int NUM_CELLS  = 10;
   localparam int ROW_CLOCKS = 6;
   localparam int LOCAL_CTL  = 8;
   localparam int CTL_MAX    = 10;
   localparam logic FLOP_RST = 1'b0;
   // flop data sources
   localparam logic [1:0] DSEL_LUT   = 2'h0;
   localparam logic [1:0] DSEL_PACK  = 2'h1;
   localparam logic [1:0] DSEL_CHAIN = 2'h2;
   // clock index 3 means no cluster clock
   localparam logic [1:0] CLK_NONE = 2'h3;
   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic       src;      // which of two sources
      logic       fall;     // falling edge when set
      logic [2:0] ena_idx;  // local line for enable
   } clk_cfg_t;
   typedef struct packed {
      clk_cfg_t [2:0]       clk;
      logic [1:0][2:0]      src_row;   // row line per source
      logic [1:0][2:0]      aclr_row;  // row line per clear
      logic [2:0]           sclr_idx;  // local line
      logic [2:0]           sload_idx; // local line
   } cluster_cfg_t;
   typedef struct packed {
      logic [2:0] tick;   // gated cluster clocks
      logic [2:0] ena;    // cluster clock enables
      logic [1:0] aclr;
      logic       sclr;
      logic       sload;
   } ctl_bus_t;
   typedef struct packed {
      logic [1:0] clk_idx;
      logic       aclr_idx;
      logic       sclr_en;
      logic       sload_en;
      logic [1:0] dsel;
   } flop_cfg_t;
   typedef struct packed {
      logic [63:0]     lut_top;
      logic [63:0]     lut_bot;
      logic            seven;    // extended mux function
      logic            fb;       // top flop feeds bottom half
      flop_cfg_t [1:0] flop;     // [0] top, [1] bottom
      logic [1:0][1:0] out_reg;  // per set, per output
   } cell_cfg_t;
   typedef struct packed {
      logic in_a;
      logic in_b;
      logic in_c;
      logic in_d;
      logic cell_input_e_top;
      logic cell_input_f_top;
      logic cell_input_e_bottom;
      logic cell_input_f_bottom;
   } cell_in_t;
   typedef struct packed {
      logic [1:0] route_top;
      logic [1:0] route_bot;
      logic       local_top;
      logic       local_bot;
      logic [1:0] q;
      logic [1:0] comb;
   } cell_out_t;
endpackage
`default_nettype wire

// ===== adaptive_logic_cell.sv
// one adaptive logic cell: two lookup halves, two flops, drivers
`timescale 1ns/10ps
`default_nettype none
module adaptive_logic_cell
(
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // configuration and cluster controls
   input  wire logic_cluster_pkg::cell_cfg_t cfg,
   input  wire logic_cluster_pkg::ctl_bus_t  ctl,
   // data inputs and chains
   input  wire logic_cluster_pkg::cell_in_t  din,
   input  wire logic                         carry_in,
   input  wire logic                         share_in,
   input  wire logic                         chain_in,
   // results
   output logic_cluster_pkg::cell_out_t      dout,
   output logic                              carry_out,
   output logic                              share_out
);
   // ----------------------------------------
   // lookup halves
   // ----------------------------------------
   function automatic logic lut6(input logic [63:0] m, input logic [5:0] i);
      return m[i];
   endfunction
   logic [1:0] q;          // top_cell_flop, bottom_cell_flop
   logic [1:0] comb;       // lookup results
   logic       f_bot;      // bottom f input or feedback
   logic [3:0] abcd;       // inputs shared by both halves
   assign abcd  = {din.in_d, din.in_c, din.in_b, din.in_a};
   assign f_bot = cfg.fb ? q[0] : din.cell_input_f_bottom;
   // top half: six-input on a-d plus top pair, or the seven-input mux
   always_comb
   begin
      if (cfg.seven)
         comb[0] = din.cell_input_f_top ?
            lut6(cfg.lut_bot, {1'b0, din.cell_input_e_bottom, abcd}) :
            lut6(cfg.lut_top, {1'b0, din.cell_input_e_top, abcd});
      else
         comb[0] = lut6(cfg.lut_top, {din.cell_input_f_top, din.cell_input_e_top, abcd});
      // bottom half: a-d plus bottom pair; equal masks give shared functions
      comb[1] = lut6(cfg.lut_bot, {f_bot, din.cell_input_e_bottom, abcd});
   end
   // ----------------------------------------
   // flops
   // ----------------------------------------
   genvar k;
   generate
      for (k = 0; k < 2; k++)
      begin : g_flop
         logic pack;   // packing input: e top for top, f bottom for bottom
         logic data;
         logic tick;
         assign pack = (k == 0) ? din.cell_input_e_top : din.cell_input_f_bottom;
         always_comb
         begin
            unique case (cfg.flop[k].dsel)
               logic_cluster_pkg::DSEL_PACK:  data = pack;
               logic_cluster_pkg::DSEL_CHAIN: data = (k == 0) ? chain_in : q[0];
               default:                       data = comb[k];
            endcase
         end
         assign tick = (cfg.flop[k].clk_idx != logic_cluster_pkg::CLK_NONE) &&
                       ctl.tick[cfg.flop[k].clk_idx];
         // clear wins over everything, even with no tick
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               q[k] <= logic_cluster_pkg::FLOP_RST;
            else if (ctl.aclr[cfg.flop[k].aclr_idx])
               q[k] <= logic_cluster_pkg::FLOP_RST;
            else if (tick)
            begin
               if (cfg.flop[k].sclr_en && ctl.sclr)
                  q[k] <= logic_cluster_pkg::FLOP_RST;
               else if (cfg.flop[k].sload_en && ctl.sload)
                  q[k] <= pack;
               else
                  q[k] <= data;
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // output drivers
   // ----------------------------------------
   // each route output picks flop or lookup on its own, so both can show
   always_comb
   begin
      dout.route_top[0] = cfg.out_reg[0][0] ? q[0] : comb[0];
      dout.route_top[1] = cfg.out_reg[0][1] ? q[0] : comb[0];
      dout.route_bot[0] = cfg.out_reg[1][0] ? q[1] : comb[1];
      dout.route_bot[1] = cfg.out_reg[1][1] ? q[1] : comb[1];
      dout.local_top    = dout.route_top[0];
      dout.local_bot    = dout.route_bot[0];
      dout.q            = q;
      dout.comb         = comb;
   end
   // arithmetic chains are not used in normal mode; pass them on
   assign carry_out = carry_in;
   assign share_out = share_in;
endmodule // adaptive_logic_cell
`default_nettype wire

// ===== logic_cluster.sv
// logic cluster: control block, ten cells, registered outputs
`timescale 1ns/10ps
`default_nettype none
module logic_cluster
(
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   // control sources
   input  wire logic [5:0]                      row_clock,
   input  wire logic [7:0]                      local_ctl,
   // configuration
   input  wire logic_cluster_pkg::cluster_cfg_t cluster_cfg,
   input  wire logic_cluster_pkg::cell_cfg_t [9:0] cell_cfg,
   // data from the fabric
   input  wire logic_cluster_pkg::cell_in_t [9:0]  cell_in,
   input  wire logic                            carry_in,
   input  wire logic                            share_in,
   input  wire logic                            chain_in,
   // results to the fabric
   output logic_cluster_pkg::cell_out_t [9:0]   cell_out,
   output logic                                 carry_out,
   output logic                                 share_out,
   output logic [2:0]                           tick_out
);
   // ----------------------------------------
   // source pickers
   // ----------------------------------------
   // row index above five selects a quiet line
   function automatic logic pick_row(input logic [2:0] i, input logic [5:0] r);
      return (i < 3'h6) ? r[i] : 1'b0;
   endfunction
   function automatic logic pick_local(input logic [2:0] i, input logic [7:0] l);
      return l[i];
   endfunction
   // ----------------------------------------
   // control block
   // ----------------------------------------
   logic [1:0] src_now;    // selected clock sources
   logic [1:0] src_prev;   // last sampled value
   logic [1:0] src_rise;
   logic [1:0] src_fall;
   logic_cluster_pkg::ctl_bus_t ctl;  // ten control signals
   // two sources from the row lines
   always_comb
   begin
      for (int s = 0; s < 2; s++)
      begin
         src_now[s] = pick_row(cluster_cfg.src_row[s], row_clock);
      end
   end
   // edge history for the clock sources
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         src_prev <= 2'h0;
      else
         src_prev <= src_now;
   end
   assign src_rise = src_now & ~src_prev;
   assign src_fall = ~src_now & src_prev;
   // cluster clocks: one edge of one source, gated by own enable
   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         ctl.ena[k]  = pick_local(cluster_cfg.clk[k].ena_idx, local_ctl);
         ctl.tick[k] = ctl.ena[k] &&
            (cluster_cfg.clk[k].fall ? src_fall[cluster_cfg.clk[k].src] :
                                       src_rise[cluster_cfg.clk[k].src]);
      end
      for (int j = 0; j < 2; j++)
      begin
         ctl.aclr[j] = pick_row(cluster_cfg.aclr_row[j], row_clock);
      end
      ctl.sclr  = pick_local(cluster_cfg.sclr_idx, local_ctl);
      ctl.sload = pick_local(cluster_cfg.sload_idx, local_ctl);
   end
   // ----------------------------------------
   // cells
   // ----------------------------------------
   logic_cluster_pkg::cell_out_t [9:0] raw;   // unregistered cell results
   logic [10:0] carry_c;                      // carry chain taps
   logic [10:0] share_c;                      // shared chain taps
   logic [10:0] chain_c;                      // register chain taps
   assign carry_c[0] = carry_in;
   assign share_c[0] = share_in;
   assign chain_c[0] = chain_in;
   genvar i;
   generate
      for (i = 0; i < logic_cluster_pkg::NUM_CELLS; i++)
      begin : g_cell
         adaptive_logic_cell u_cell
         (
            .clk       (clk),
            .rst_n     (rst_n),
            .cfg       (cell_cfg[i]),
            .ctl       (ctl),
            .din       (cell_in[i]),
            .carry_in  (carry_c[i]),
            .share_in  (share_c[i]),
            .chain_in  (chain_c[i]),
            .dout      (raw[i]),
            .carry_out (carry_c[i+1]),
            .share_out (share_c[i+1])
         );
         // register chain takes the bottom flop onward
         assign chain_c[i+1] = raw[i].q[1];
      end
   endgenerate
   // ----------------------------------------
   // output stage
   // ----------------------------------------
   // one fabric-clock stage keeps every output on a flop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cell_out  <= '0;
         carry_out <= 1'b0;
         share_out <= 1'b0;
         tick_out  <= 3'h0;
      end
      else
      begin
         cell_out  <= raw;
         carry_out <= carry_c[10];
         share_out <= share_c[10];
         tick_out  <= ctl.tick;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // helper: selected clear of cell zero top flop
   logic aclr0;
   logic tick0;
   assign aclr0 = ctl.aclr[cell_cfg[0].flop[0].aclr_idx];
   assign tick0 = (cell_cfg[0].flop[0].clk_idx != logic_cluster_pkg::CLK_NONE) &&
                  ctl.tick[cell_cfg[0].flop[0].clk_idx];
   ctl_count_a: assert property ($countones(ctl) <= logic_cluster_pkg::CTL_MAX)
      else $error("more than ten control signals active");
   tick_needs_ena_a: assert property (!(|(ctl.tick & ~ctl.ena)))
      else $error("cluster clock ticked with enable low");
   rise_tick_a: assert property (
      ctl.ena[0] && !cluster_cfg.clk[0].fall &&
      $rose(src_now[cluster_cfg.clk[0].src]) && $stable(cluster_cfg) |-> ctl.tick[0])
      else $error("rising source edge missed by clock one");
   fall_tick_a: assert property (
      ctl.tick[1] && cluster_cfg.clk[1].fall |->
      !src_now[cluster_cfg.clk[1].src] && src_prev[cluster_cfg.clk[1].src])
      else $error("falling clock ticked without a falling edge");
   aclr_wins_a: assert property (aclr0 |=> !raw[0].q[0])
      else $error("async clear lost to another control");
   sclr_tick_a: assert property (
      tick0 && !aclr0 && ctl.sclr && cell_cfg[0].flop[0].sclr_en |=> !raw[0].q[0])
      else $error("sync clear did not clear the flop");
   hold_no_tick_a: assert property (
      !tick0 && !aclr0 |=> $stable(raw[0].q[0]))
      else $error("flop changed without its cluster clock");
   out_stage_a: assert property (
      ##1 cell_out[0] == $past(raw[0]) && tick_out == $past(ctl.tick))
      else $error("output stage lags by other than one cycle");
   local_drv_a: assert property (cell_out[0].local_top == cell_out[0].route_top[0])
      else $error("local driver differs from its route output");
   // main scenarios
   rise_c:  cover property (ctl.tick[0] && !cluster_cfg.clk[0].fall);
   fall_c:  cover property (ctl.tick[1] && cluster_cfg.clk[1].fall);
   aclr_c:  cover property (aclr0 && tick0);
   sload_c: cover property (tick0 && ctl.sload && cell_cfg[0].flop[0].sload_en);
endmodule // logic_cluster
`default_nettype wire

// ===== cluster_fabric_model.sv
// routing fabric model that drives the cluster row clock lines
`timescale 1ns/10ps
`default_nettype none
module cluster_fabric_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // pulse request from the bench
   input  wire logic       go,
   input  wire logic [5:0] sel_mask,
   input  wire logic [3:0] width,
   // row lines into the cluster
   output var  logic [5:0] row_clock
);
   // --------------------------------
   // pulse timing
   // --------------------------------
   logic [3:0] left;   // cycles the pulse still stands
   // lines rest low between pulses, like a stopped clock, so no stray edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_clock <= 6'h00;
         left      <= 4'h0;
      end
      else if (go)
      begin
         row_clock <= sel_mask;
         left      <= width;
      end
      else if (left != 4'h0)
      begin
         left <= left - 4'h1;
         // drop every raised line once the width is used up
         if (left == 4'h1)
            row_clock <= 6'h00;
      end
   end
endmodule // cluster_fabric_model
`default_nettype wire

// ===== logic_cluster_test.sv
// self-checking bench for the logic cluster
`timescale 1ns/10ps
`default_nettype none
module logic_cluster_test;
   // --------------------------------
   // signals
   // --------------------------------
   localparam logic_cluster_pkg::flop_cfg_t IDLE_FLOP =
      '{logic_cluster_pkg::CLK_NONE, 1'b1, 1'b0, 1'b0, logic_cluster_pkg::DSEL_LUT};
   logic                               clk = 1'b0;
   logic                               rst_n = 1'b0;
   logic                               go = 1'b0;       // fabric pulse request
   logic [5:0]                         sel_mask = 6'h00;
   logic [3:0]                         width = 4'h0;
   logic [5:0]                         row_clock;
   logic [7:0]                         local_ctl = 8'h00;
   logic_cluster_pkg::cluster_cfg_t    cluster_cfg;
   logic_cluster_pkg::cell_cfg_t [9:0] cell_cfg;
   logic_cluster_pkg::cell_in_t [9:0]  cell_in = '0;
   logic_cluster_pkg::cell_out_t [9:0] cell_out;
   logic [2:0]                         tick_out;
   logic                               carry_in = 1'b0;   // chain inputs into cell zero
   logic                               share_in = 1'b0;
   logic                               carry_out;
   logic                               share_out;
   int                                 error_cnt = 0;
   int                                 n_compared = 0;
   int                                 cycles = 0;
   // ordinary cases: inputs a..f_bottom, then {seven-input top, bottom, top} lookup results
   logic [7:0] row_in [6]  = '{8'h00, 8'hff, 8'h80, 8'hf3, 8'h04, 8'hf7};
   logic [2:0] row_exp [6] = '{3'b000, 3'b110, 3'b101, 3'b010, 3'b001, 3'b111};

   always #4 clk = ~clk;

   cluster_fabric_model cluster_fabric_model_inst (.clk(clk), .rst_n(rst_n), .go(go),
      .sel_mask(sel_mask), .width(width), .row_clock(row_clock));
   logic_cluster logic_cluster_inst (.clk(clk), .rst_n(rst_n), .row_clock(row_clock),
      .local_ctl(local_ctl), .cluster_cfg(cluster_cfg), .cell_cfg(cell_cfg), .cell_in(cell_in),
      .carry_in(carry_in), .share_in(share_in), .chain_in(1'b0), .cell_out(cell_out), .carry_out(carry_out),
      .share_out(share_out), .tick_out(tick_out));

   // --------------------------------
   // helpers
   // --------------------------------
   task close_out;
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard: whole run needs about seventy-five cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 1000)
      begin
         error_cnt++;
         close_out();
      end
   end
   task chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // new controls and data at one edge, fabric raises the lines at the next
   task drive(input logic [7:0] ctl, input logic [7:0] din, input logic [5:0] msk, input logic [3:0] w);
      @(posedge clk);
      local_ctl <= ctl;
      cell_in   <= {10{din}};
      go        <= (msk != 6'h00);
      sel_mask  <= msk;
      width     <= w;
      @(posedge clk);
      go        <= 1'b0;
      #1;
   endtask

   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      // clock 0 rising, clock 1 falling of source 0, clock 2 of source 1
      cluster_cfg = '0;
      cluster_cfg.clk[1].fall = 1'b1;
      cluster_cfg.clk[1].ena_idx = 3'h1;
      cluster_cfg.clk[2].src = 1'b1;
      cluster_cfg.clk[2].ena_idx = 3'h2;
      cluster_cfg.src_row[1] = 3'h1;
      cluster_cfg.aclr_row = {3'h6, 3'h2};   // second clear on a quiet line
      cluster_cfg.sclr_idx = 3'h3;
      cluster_cfg.sload_idx = 3'h4;
      for (int i = 0; i < 10; i++)
      begin
         cell_cfg[i] = '0;
         cell_cfg[i].flop = {IDLE_FLOP, IDLE_FLOP};
      end
      // cell 0: top parity of six, bottom and of six
      cell_cfg[0].lut_top = 64'h6996966996696996;
      cell_cfg[0].lut_bot = 64'h8000000000000000;
      cell_cfg[0].flop[0] = '{2'h0, 1'b0, 1'b1, 1'b1, logic_cluster_pkg::DSEL_LUT};
      cell_cfg[0].flop[1] = '{2'h1, 1'b1, 1'b0, 1'b0, logic_cluster_pkg::DSEL_LUT};
      cell_cfg[0].out_reg[0] = 2'b10;
      // cell 1: chained top flop fed back into the bottom half
      cell_cfg[1].fb = 1'b1;
      cell_cfg[1].lut_bot = 64'hffffffff00000000;
      cell_cfg[1].flop[0] = '{2'h0, 1'b1, 1'b0, 1'b0, logic_cluster_pkg::DSEL_CHAIN};
      // cell 2: packed top flop on clock 2
      cell_cfg[2].flop[0] = '{2'h2, 1'b1, 1'b0, 1'b0, logic_cluster_pkg::DSEL_PACK};
      // cell 3: seven-input mux, f top picks between two five-input halves
      cell_cfg[3].seven   = 1'b1;
      cell_cfg[3].lut_top = 64'h0000000096696996;
      cell_cfg[3].lut_bot = 64'h0000000080000000;
      step(16);
      chk("reset outputs", 3'h0, {1'b0, |cell_out, |tick_out});
      rst_n <= 1'b1;
      // combinational table, flops bypassed
      for (int i = 0; i < 6; i++)
      begin
         drive(8'h00, row_in[i], 6'h00, 4'h0);
         chk("comb", row_exp[i], {cell_out[3].comb[0], cell_out[0].comb});
         chk("top drivers", {row_exp[i][0], row_exp[i][0], 1'b0},
             {cell_out[0].route_top[0], cell_out[0].local_top, cell_out[0].route_top[1]});
         chk("bottom drivers", {3{row_exp[i][1]}}, {cell_out[0].route_bot, cell_out[0].local_bot});
      end
      // rising then falling edge of one source on two cluster clocks
      drive(8'h07, 8'h80, 6'h01, 4'h4);
      step(1);
      chk("tick rise", 3'b001, tick_out);
      step(1);
      chk("tick one cycle", 3'b000, tick_out);
      chk("q after rise", 3'b001, 3'(cell_out[0].q));
      drive(8'h07, 8'hf3, 6'h00, 4'h0);
      chk("reg and comb", 3'b010, 3'(cell_out[0].route_top));
      step(1);
      chk("tick fall", 3'b010, tick_out);
      step(1);
      chk("q after fall", 3'b011, 3'(cell_out[0].q));
      // chain into cell 1, its flop fed back, its bottom flop never clocked
      drive(8'h07, 8'h00, 6'h01, 4'h1);
      step(2);
      chk("chain feedback", 3'b011, {cell_out[1].q[1], cell_out[1].comb[1], cell_out[1].q[0]});
      step(1);
      chk("q cleared", 3'b000, 3'(cell_out[0].q));
      // enables low: edges on both sources are dropped
      drive(8'h00, 8'h88, 6'h03, 4'h2);
      step(1);
      chk("gated rise", 3'b000, tick_out);
      step(2);
      chk("gated fall", 3'b000, tick_out);
      chk("gated q", 3'b000, {cell_out[2].q[0], cell_out[0].q});
      // third clock from the second source loads the packing input
      drive(8'h04, 8'h08, 6'h02, 4'h1);
      step(1);
      chk("tick third", 3'b100, tick_out);
      step(1);
      chk("pack q", 3'b100, {cell_out[2].q[0], cell_out[0].q});
      // load, clear over load, load, then async clear over load
      drive(8'h11, 8'h18, 6'h01, 4'h1);
      step(2);
      chk("sload", 3'b001, 3'(cell_out[0].q[0]));
      drive(8'h19, 8'h8c, 6'h01, 4'h1);
      step(2);
      chk("sclr", 3'b000, 3'(cell_out[0].q[0]));
      drive(8'h11, 8'h18, 6'h01, 4'h1);
      step(2);
      chk("reload", 3'b001, 3'(cell_out[0].q[0]));
      drive(8'h11, 8'h18, 6'h05, 4'h1);
      step(2);
      chk("aclr wins", 3'b000, 3'(cell_out[0].q[0]));
      // chains run through all ten cells to the registered outputs
      @(posedge clk);
      carry_in <= 1'b1;
      step(2);
      chk("chain outputs", 3'b010, {1'b0, carry_out, share_out});
      // mid-run reset clears every flop and output at once
      @(posedge clk);
      rst_n <= 1'b0;
      step(1);
      chk("mid reset", 3'h0, {carry_out, |cell_out, |tick_out});
      rst_n <= 1'b1;
      step(2);
      chk("after reset", 3'h0, {cell_out[2].q[0], cell_out[0].q});
      close_out();
   end
endmodule // logic_cluster_test
`default_nettype wire
